// ---- design/anp_notify.sv ----
/*
 * notification pin: function select, polarity, forced-inactive state.
 * assumes source levels come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module anp_notify
    import anp_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     arst_n,
    anp_link_if.ntf_mp    lk
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic pin_q, pin_d;     // pin level
    logic force_q, force_d; // held inactive after a config write
    logic src;              // selected source level
    logic active;           // pin should be active

    // next values: source select and polarity
    always_comb begin
        case (lk.func)
            FN_ALARM: src = lk.alarm;
            FN_DRDY:  src = lk.drdy;
            FN_BUSY:  src = lk.busy;
            FN_EARLY: src = lk.early & (lk.operating_mode_sel == MODE_CONT);
            default:  src = 1'b0;      // off and reserved
        endcase
        // hold inactive until the source drops
        if (lk.cfg_wr) begin
            force_d = 1'b1;
        end else if (!src) begin
            force_d = 1'b0;
        end else begin
            force_d = force_q;
        end
        active = src & ~force_q & ~lk.cfg_wr;
        pin_d  = lk.polarity ? active : ~active;
    end

    // registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q   <= RST_PIN;
            force_q <= 1'b0;
        end else begin
            pin_q   <= pin_d;
            force_q <= force_d;
        end
    end

    assign lk.pin = pin_q;

endmodule

`default_nettype wire

// ---- design/anp_pres.sv ----
/*
 * pressure compensation byte pair with shadow copy and range clamp.
 * assumes write strobes from the register decoder on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module anp_pres
    import anp_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     arst_n,
    anp_link_if.pres_mp   lk
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]  msb_q, msb_d;       // high byte
    logic [7:0]  lsb_q, lsb_d;       // low byte
    logic [15:0] shadow_q, shadow_d; // value used by the firmware
    logic        err_q, err_d;       // out-of-range pulse
    logic        upd_q, upd_d;       // compensation active
    logic [15:0] raw;                // value being written

    // next values: clamp on low-byte write
    always_comb begin
        raw      = {msb_q, lk.wdata};
        msb_d    = msb_q;
        lsb_d    = lsb_q;
        shadow_d = shadow_q;
        err_d    = 1'b0;
        upd_d    = upd_q;
        if (lk.wr_pres_msb) begin
            msb_d = lk.wdata;          // shadow untouched
        end
        if (lk.wr_pres_lsb) begin
            upd_d = 1'b1;
            if (raw < PRES_MIN) begin
                shadow_d = PRES_MIN;
                err_d    = 1'b1;
            end else if (raw > PRES_MAX) begin
                shadow_d = PRES_MAX;
                err_d    = 1'b1;
            end else begin
                shadow_d = raw;        // full copy
            end
            msb_d = shadow_d[15:8];    // write-back
            lsb_d = shadow_d[7:0];
        end
    end

    // registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            msb_q    <= RST_PRES_MSB;
            lsb_q    <= RST_PRES_LSB;
            shadow_q <= {RST_PRES_MSB, RST_PRES_LSB};
            err_q    <= 1'b0;
            upd_q    <= 1'b0;
        end else begin
            msb_q    <= msb_d;
            lsb_q    <= lsb_d;
            shadow_q <= shadow_d;
            err_q    <= err_d;
            upd_q    <= upd_d;
        end
    end

    assign lk.pres_msb     = msb_q;
    assign lk.pres_lsb     = lsb_q;
    assign lk.pres_shadow  = shadow_q;
    assign lk.range_err    = err_q;
    assign lk.pres_updated = upd_q;

endmodule

`default_nettype wire

// ---- design/anp_regs.sv ----
/*
 * alarm, notify-pin and pressure register slice: bus decode, threshold
 * compare at end of measurement, sticky events and interrupt.
 * assumes measurement inputs come from logic on the same clock, and a
 * bus master with one-cycle strobes that never overlap.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module anp_regs
    import anp_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire logic [anp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [anp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [anp_pkg::DATA_W-1:0]      reg_rdata,
    input  wire logic                meas_done,
    input  wire logic [15:0]         co2_value,
    input  wire logic                data_ready,
    input  wire logic                sensor_busy,
    input  wire logic                early_start,
    output logic                     notify_pin,
    output logic                     irq,
    output logic [15:0]              pres_shadow,
    output logic                     pres_comp_en
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]         th_msb_q, th_msb_d;     // alarm_threshold_msb
    logic [7:0]         th_lsb_q, th_lsb_d;     // alarm_threshold_lsb
    logic [4:0]         ntf_q, ntf_d;           // notify_pin_config
    logic [1:0]         mode_q, mode_d;         // operating_mode_sel
    logic [NUM_EVT-1:0] sts_q, sts_d;           // sensor_status_reg
    logic [NUM_EVT-1:0] mask_q, mask_d;         // interrupt mask
    logic [7:0]         rdata_q, rdata_d;       // read answer
    logic               irq_q, irq_d;           // interrupt level

    logic               wr_sts;                 // write to status
    logic               viol;                   // threshold crossed
    logic signed [15:0] thr;                    // signed threshold
    logic signed [15:0] co2;                    // signed result
    logic [NUM_EVT-1:0] evt;                    // event pulses
    logic [NUM_EVT-1:0] sts_nx;                 // status next per bit

    anp_link_if lk ();                          // internal carrier

    // ------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------
    anp_pres u_pres (
        .clk    (clk),
        .arst_n (arst_n),
        .lk     (lk.pres_mp)
    );

    anp_notify u_notify (
        .clk    (clk),
        .arst_n (arst_n),
        .lk     (lk.ntf_mp)
    );

    // drive the carrier from the register port, the register state and the sensor inputs
    assign lk.wr_pres_msb = reg_wr & hit(reg_addr, OFF_PRES_MSB);
    assign lk.wr_pres_lsb = reg_wr & hit(reg_addr, OFF_PRES_LSB);
    assign lk.wdata       = reg_wdata;
    assign lk.cfg_wr      = reg_wr & hit(reg_addr, OFF_NOTIFY_CFG);
    assign lk.polarity    = lk.cfg_wr ? reg_wdata[NTF_POL_BIT]
                                      : ntf_q[NTF_POL_BIT];
    assign lk.func        = ntf_q[NTF_FUNC_MSB:NTF_FUNC_LSB];
    assign lk.operating_mode_sel     = mode_q;
    assign lk.alarm       = sts_q[ST_ALARM];
    assign lk.drdy        = data_ready;
    assign lk.busy        = sensor_busy;
    assign lk.early       = early_start;

    // ------------------------------------------------------------------
    // threshold compare
    // ------------------------------------------------------------------
    // signed compare, direction picks the side of the limit
    always_comb begin
        thr = signed'({th_msb_q, th_lsb_q});
        co2 = signed'(co2_value);
        if (ntf_q[NTF_DIR_BIT]) begin
            viol = (co2 > thr);                         // upper
        end else begin
            viol = (co2 < thr);                         // lower
        end
    end

    // ------------------------------------------------------------------
    // sticky events
    // ------------------------------------------------------------------
    assign wr_sts = reg_wr & hit(reg_addr, OFF_SENSOR_STS);
    assign evt[ST_ALARM] = meas_done & viol;
    assign evt[ST_RANGE] = lk.range_err;
    assign evt[ST_DRDY]  = meas_done;

    // set wins over a write-one clear
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_sts
            assign sts_nx[gi] = evt[gi] |
                (sts_q[gi] & ~(wr_sts & reg_wdata[gi]));
        end
    endgenerate

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // next values of the software-visible registers
    always_comb begin
        th_msb_d = th_msb_q;
        th_lsb_d = th_lsb_q;
        ntf_d    = ntf_q;
        mode_d   = mode_q;
        mask_d   = mask_q;
        sts_d    = sts_nx;
        if (reg_wr) begin
            if (hit(reg_addr, OFF_TH_MSB)) begin
                th_msb_d = reg_wdata;
            end
            if (hit(reg_addr, OFF_TH_LSB)) begin
                th_lsb_d = reg_wdata;
            end
            if (hit(reg_addr, OFF_NOTIFY_CFG)) begin
                ntf_d = reg_wdata[NTF_CFG_MSB:0];   // 7:5 dropped
            end
            if (hit(reg_addr, OFF_MEASUREMENT_CONFIG_REG)) begin
                mode_d = reg_wdata[MODE_MSB:0];
            end
            if (hit(reg_addr, OFF_IRQ_MASK)) begin
                mask_d = reg_wdata[NUM_EVT-1:0];
            end
        end
        irq_d = |(sts_nx & mask_d);
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    // answer stands only in the cycle after the read strobe
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFF_SENSOR_STS: rdata_d = {5'h00, sts_q};
                OFF_MEASUREMENT_CONFIG_REG:   rdata_d = {6'h00, mode_q};
                OFF_NOTIFY_CFG: rdata_d = {3'h0, ntf_q};
                OFF_TH_MSB:     rdata_d = th_msb_q;
                OFF_TH_LSB:     rdata_d = th_lsb_q;
                OFF_PRES_MSB:   rdata_d = lk.pres_msb;
                OFF_PRES_LSB:   rdata_d = lk.pres_lsb;
                OFF_IRQ_MASK:   rdata_d = {5'h00, mask_q};
                default:        rdata_d = 8'h00;         // unmapped
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            th_msb_q <= RST_TH;
            th_lsb_q <= RST_TH;
            ntf_q    <= RST_NOTIFY;
            mode_q   <= RST_MODE;
            sts_q    <= RST_EVT;
            mask_q   <= RST_EVT;
            rdata_q  <= 8'h00;
            irq_q    <= 1'b0;
        end else begin
            th_msb_q <= th_msb_d;
            th_lsb_q <= th_lsb_d;
            ntf_q    <= ntf_d;
            mode_q   <= mode_d;
            sts_q    <= sts_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata    = rdata_q;
    assign irq          = irq_q;
    assign notify_pin   = lk.pin;             // flop in the notify block
    assign pres_shadow  = lk.pres_shadow;     // flop in the pressure block
    assign pres_comp_en = lk.pres_updated;

endmodule

`default_nettype wire

// ---- pkg/anp_link_if.sv ----
/*
 * internal carrier between the register slice top and its pressure
 * and notify-pin submodules. assumes one clock and reset domain.
 */
`timescale 1ns/100ps
`default_nettype none

interface anp_link_if;

    // ------------------------------------------------------------------
    // pressure group
    // ------------------------------------------------------------------
    logic        wr_pres_msb;  // write strobe, high byte
    logic        wr_pres_lsb;  // write strobe, low byte
    logic [7:0]  wdata;        // bus write data
    logic [7:0]  pres_msb;     // stored high byte
    logic [7:0]  pres_lsb;     // stored low byte
    logic [15:0] pres_shadow;  // coherent copy for the firmware
    logic        range_err;    // one-cycle out-of-range pulse
    logic        pres_updated; // default overwritten at least once

    // ------------------------------------------------------------------
    // notify group
    // ------------------------------------------------------------------
    logic        cfg_wr;       // write to notify config
    logic        polarity;     // 1 active high
    logic [2:0]  func;         // pin function
    logic [1:0]  operating_mode_sel;      // operating mode
    logic        alarm;        // sticky alarm
    logic        drdy;         // data ready level
    logic        busy;         // sensor busy level
    logic        early;        // early start level
    logic        pin;          // registered pin level

    modport top_mp (output wr_pres_msb, wr_pres_lsb, wdata, cfg_wr,
                    polarity, func, operating_mode_sel, alarm, drdy, busy, early,
                    input pres_msb, pres_lsb, pres_shadow, range_err,
                    pres_updated, pin);
    modport pres_mp (input wr_pres_msb, wr_pres_lsb, wdata,
                     output pres_msb, pres_lsb, pres_shadow, range_err,
                     pres_updated);
    modport ntf_mp (input cfg_wr, polarity, func, operating_mode_sel, alarm, drdy,
                    busy, early, output pin);

endinterface

`default_nettype wire

// ---- pkg/anp_pkg.sv ----
/*
 * constants of the alarm / notify / pressure register slice:
 * offsets, field positions, reset values, function codes and limits.
 * assumes an 8-bit register space reached over a plain strobe port.
 */
package anp_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;           // register address width
    localparam int unsigned DATA_W = 8;           // register data width
    localparam int unsigned NUM_EVT = 3;          // sticky status events

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_SENSOR_STS = 8'h01; // sticky event flags
    localparam logic [7:0] OFF_MEASUREMENT_CONFIG_REG   = 8'h04; // operating mode
    localparam logic [7:0] OFF_NOTIFY_CFG = 8'h08; // notify pin config
    localparam logic [7:0] OFF_TH_MSB     = 8'h09; // threshold high byte
    localparam logic [7:0] OFF_TH_LSB     = 8'h0A; // threshold low byte
    localparam logic [7:0] OFF_PRES_MSB   = 8'h0B; // pressure high byte
    localparam logic [7:0] OFF_PRES_LSB   = 8'h0C; // pressure low byte
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h10; // interrupt mask

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_TH        = 8'h00; // both threshold bytes
    localparam logic [7:0] RST_PRES_MSB  = 8'h03; // pressure high byte
    localparam logic [7:0] RST_PRES_LSB  = 8'hF7; // pressure low byte
    localparam logic [4:0] RST_NOTIFY    = 5'h00; // low active, disabled
    localparam logic [1:0] RST_MODE      = 2'h0;  // operating mode
    localparam logic [2:0] RST_EVT       = 3'h0;  // status and mask
    localparam logic       RST_PIN       = 1'b1;  // inactive, low active

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned NTF_POL_BIT  = 4;     // notify_polarity
    localparam int unsigned NTF_FUNC_LSB = 1;     // notify_function_sel
    localparam int unsigned NTF_FUNC_MSB = 3;
    localparam int unsigned NTF_DIR_BIT  = 0;     // threshold_direction
    localparam int unsigned NTF_CFG_MSB  = 4;     // top stored cfg bit
    localparam int unsigned MODE_MSB     = 1;     // operating_mode_sel
    localparam int unsigned ST_ALARM     = 0;     // threshold violation
    localparam int unsigned ST_RANGE     = 1;     // range_config_error_flag
    localparam int unsigned ST_DRDY      = 2;     // measurement finished

    // ------------------------------------------------------------------
    // codes and limits
    // ------------------------------------------------------------------
    localparam logic [2:0]  FN_OFF   = 3'h0;      // pin inactive
    localparam logic [2:0]  FN_ALARM = 3'h1;      // threshold violation
    localparam logic [2:0]  FN_DRDY  = 3'h2;      // data ready
    localparam logic [2:0]  FN_BUSY  = 3'h3;      // sensor busy
    localparam logic [2:0]  FN_EARLY = 3'h4;      // early meas start
    localparam logic [1:0]  MODE_CONT = 2'h2;     // continuous mode
    localparam logic [15:0] PRES_MIN = 16'h02EE;  // 750 hPa
    localparam logic [15:0] PRES_MAX = 16'h047E;  // 1150 hPa

endpackage

// ---- test/alarm_notify_pressure_regs_bench.sv ----
/*
 * bench of the slice: resets, pin functions, pressure, alarm, irq.
 * assumes the host model drives the register port.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end

module alarm_notify_pressure_regs_bench;
    import anp_pkg::*;
    logic        clk, arst_n, meas_done, data_ready, sensor_busy;
    logic        early_start, reg_wr, reg_rd, notify_pin, irq, pres_comp_en;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [15:0] co2_value, pres_shadow;
    int          err_count = 0;
    int          compares = 0;

    anp_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    anp_regs i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .meas_done(meas_done),
        .co2_value(co2_value), .data_ready(data_ready),
        .sensor_busy(sensor_busy), .early_start(early_start),
        .notify_pin(notify_pin), .irq(irq), .pres_shadow(pres_shadow),
        .pres_comp_en(pres_comp_en));

    // ------------------------------------------------------------------
    // clock, watchdog, helpers
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic src(input logic v);
        @(posedge clk);
        data_ready  <= v;
        sensor_busy <= v;
        early_start <= v;
    endtask
    // pin function set with sources low, then data_ready, sensor_busy and early_start raised
    task automatic pin_case(input logic [7:0] cfg, input logic exp);
        src(1'b0);
        i_host.wr(OFF_NOTIFY_CFG, cfg);
        tick(1);
        `CHK(notify_pin, ~cfg[4])
        src(1'b1);
        tick(2);
        `CHK(notify_pin, exp)
    endtask
    // one measurement end with a given result
    task automatic meas(input logic [15:0] v);
        @(posedge clk);
        co2_value <= v;
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        tick(2);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_pres();
        i_host.wr(OFF_PRES_MSB, 8'h04);
        tick(1);
        `CHK(pres_shadow, 16'h03F7)
        rchk(OFF_PRES_MSB, 8'h04);
        i_host.wr(OFF_PRES_LSB, 8'h00);
        tick(1);
        `CHK(pres_shadow, 16'h0400)
        `CHK(pres_comp_en, 1'b1)
        rchk(OFF_SENSOR_STS, 8'h00);
        i_host.wr(OFF_IRQ_MASK, 8'h02);
        i_host.wr(OFF_PRES_MSB, 8'h02);
        i_host.wr(OFF_PRES_LSB, 8'hED);     // one under the floor
        tick(3);
        `CHK(pres_shadow, PRES_MIN)
        `CHK(irq, 1'b1)
        rchk(OFF_PRES_LSB, 8'hEE);
        rchk(OFF_SENSOR_STS, 8'h02);
        i_host.wr(OFF_SENSOR_STS, 8'h02);
        tick(2);
        `CHK(irq, 1'b0)
        i_host.wr(OFF_PRES_MSB, 8'h04);
        i_host.wr(OFF_PRES_LSB, 8'h7F);     // one over the ceiling
        tick(1);
        `CHK(pres_shadow, PRES_MAX)
    endtask

    task automatic t_alarm();
        i_host.wr(OFF_SENSOR_STS, 8'h07);
        i_host.wr(OFF_IRQ_MASK, 8'h01);
        i_host.wr(OFF_TH_LSB, 8'h64);
        i_host.wr(OFF_NOTIFY_CFG, 8'h12);   // alarm pin, lower limit
        meas(16'h0064);
        rchk(OFF_SENSOR_STS, 8'h04);
        meas(16'h0032);
        `CHK(notify_pin, 1'b1)
        `CHK(irq, 1'b1)
        rchk(OFF_SENSOR_STS, 8'h05);
        i_host.wr(OFF_SENSOR_STS, 8'h07);
        i_host.wr(OFF_TH_MSB, 8'hFF);
        i_host.wr(OFF_TH_LSB, 8'h9C);       // signed limit below zero
        i_host.wr(OFF_NOTIFY_CFG, 8'h13);   // upper limit
        meas(16'hFF6A);
        rchk(OFF_SENSOR_STS, 8'h04);
        meas(16'h0032);
        rchk(OFF_SENSOR_STS, 8'h05);
    endtask

    task automatic final_report();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        arst_n      = 1'b0;
        meas_done   = 1'b0;
        co2_value   = 16'h0000;
        data_ready  = 1'b0;
        sensor_busy = 1'b0;
        early_start = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        tick(1);
        `CHK(notify_pin, 1'b1)
        `CHK(pres_shadow, 16'h03F7)
        `CHK(pres_comp_en, 1'b0)
        rchk(OFF_TH_MSB, 8'h00);
        rchk(OFF_TH_LSB, 8'h00);
        rchk(OFF_PRES_MSB, 8'h03);
        rchk(8'h20, 8'h00);
        for (int f = 0; f < 8; f++) begin
            pin_case({4'h1, f[2:0], 1'b0}, f == 2 || f == 3);
        end
        pin_case(8'h04, 1'b0);
        pin_case(8'h14, 1'b1);
        rchk(OFF_NOTIFY_CFG, 8'h14);
        i_host.wr(OFF_NOTIFY_CFG, 8'h14);
        tick(2);
        `CHK(notify_pin, 1'b0)
        i_host.wr(OFF_MEASUREMENT_CONFIG_REG, {6'h00, MODE_CONT});
        pin_case(8'h18, 1'b1);
        t_pres();
        t_alarm();
        final_report();
    end
endmodule

`default_nettype wire

// ---- test/anp_host.sv ----
/*
 * host model: drives the register port of the slice.
 * assumes one clock; strobes one cycle long, never overlapping.
 */
`timescale 1ns/100ps
`default_nettype none

module anp_host (
    input  wire logic       clk,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    // ------------------------------------------------------------------
    // idle bus
    // ------------------------------------------------------------------
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one-cycle write; released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // one-cycle read; data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

`default_nettype wire

// ---- test/anp_regs_monitor.sv ----
/*
 * checker of the slice's top ports.
 * assumes the bind below; one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none

module anp_regs_monitor
    import anp_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        meas_done,
    input wire logic [15:0] co2_value,
    input wire logic        data_ready,
    input wire logic        sensor_busy,
    input wire logic        early_start,
    input wire logic        notify_pin,
    input wire logic        irq,
    input wire logic [15:0] pres_shadow,
    input wire logic        pres_comp_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------------
    // write events
    // ------------------------------------------------------------------
    sequence cfg_wr_s;
        reg_wr && reg_addr == OFF_NOTIFY_CFG;
    endsequence
    sequence lsb_wr_s;
        reg_wr && reg_addr == OFF_PRES_LSB;
    endsequence

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    cfg_rsvd_a: assert property (
        reg_rd && reg_addr == OFF_NOTIFY_CFG |=> reg_rdata[7:5] == 3'h0)
        else $error("config upper bits read nonzero");
    cfg_force_a: assert property (
        cfg_wr_s |=> notify_pin == !$past(reg_wdata[4]))
        else $error("pin not inactive after config write");
    shadow_hold_a: assert property (
        !(reg_wr && reg_addr == OFF_PRES_LSB) |=> $stable(pres_shadow))
        else $error("shadow moved without low byte write");
    shadow_load_a: assert property (
        lsb_wr_s ##1 (pres_shadow inside {[PRES_MIN + 1:PRES_MAX - 1]})
        |-> pres_shadow[7:0] == $past(reg_wdata))
        else $error("shadow low byte not loaded");
    shadow_range_a: assert property (
        pres_comp_en |-> pres_shadow >= PRES_MIN && pres_shadow <= PRES_MAX)
        else $error("shadow outside clamp range");
    comp_set_a: assert property (lsb_wr_s |=> pres_comp_en)
        else $error("compensation not enabled by low byte write");
    comp_sticky_a: assert property (pres_comp_en |=> pres_comp_en)
        else $error("compensation enable dropped");
    comp_default_a: assert property (
        !pres_comp_en |-> pres_shadow == 16'h03F7)
        else $error("shadow changed while compensation off");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(meas_done) || $past(reg_wr)
        || $past(reg_wr, 2))
        else $error("interrupt rose without cause");
endmodule

bind anp_regs anp_regs_monitor i_mon (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_done(meas_done),
    .co2_value(co2_value), .data_ready(data_ready),
    .sensor_busy(sensor_busy), .early_start(early_start),
    .notify_pin(notify_pin), .irq(irq), .pres_shadow(pres_shadow),
    .pres_comp_en(pres_comp_en));

`default_nettype wire
